// File: rtl/bbc_regs.sv
// Configuration header registers 24h to 44h with buffering and chip control decode.
module bbc_regs
   import bbc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire bbc_cfg_req_t cfg_req,
   input wire logic cfg_from_primary,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   output logic cfg_lockout_retry,
   input wire logic [31:0] upper_setup,
   input wire logic retry_expired,
   input wire logic bridge_discard_en,
   input wire logic bridge_tmo_fwd,
   input wire logic bridge_tmo_rev,
   input wire logic test_mode_strap_a,
   input wire logic test_mode_strap_b,
   input wire logic test_mode_strap_c,
   input wire logic mask_input_strap,
   input wire logic reverse_mode_strap,
   output bbc_ctrl_t ctrl,
   output logic [31:0] upper_base,
   output logic [15:0] sec_cmd,
   output logic [7:0] intr_line,
   output logic discard_bridge_sel
);

   // ------------------------------------------------------------------
   // Strap synchronisers
   // ------------------------------------------------------------------
   // Three stages per strap; a level is accepted once stages two and three agree.
   // Straps are static in use; the filter only rides out a pin still settling
   // at power-up. Until the filtered levels arrive the block behaves as a
   // forward bridge, which is also the safe choice for the lockout and loopback bits.
   logic [4:0] strap_s1_reg;
   logic [4:0] strap_s2_reg;
   logic [4:0] strap_s3_reg;
   logic [4:0] strap_reg;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         strap_s1_reg <= 5'h00;
         strap_s2_reg <= 5'h00;
         strap_s3_reg <= 5'h00;
      end
      else
      begin
         strap_s1_reg <= {reverse_mode_strap, mask_input_strap, test_mode_strap_c,
                          test_mode_strap_b, test_mode_strap_a};
         strap_s2_reg <= strap_s1_reg;
         strap_s3_reg <= strap_s2_reg;
      end
   end

   // Filtered strap levels, updated per bit only when two stages agree.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         strap_reg <= 5'h00;
      end
      else
      begin
         for (int i = 0; i < 5; i++)
         begin
            if (strap_s2_reg[i] == strap_s3_reg[i])
            begin
               strap_reg[i] <= strap_s3_reg[i];
            end
         end
      end
   end

   logic reverse_mode;
   logic loop_straps_ok;
   assign reverse_mode = strap_reg[4];
   // Loopback strap pattern: a low, b high, c high, mask high, reverse high.
   assign loop_straps_ok = !strap_reg[0] && strap_reg[1] && strap_reg[2] && strap_reg[3]
                           && strap_reg[4];

   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   logic [31:0] be_mask;
   logic wr_ctrl;
   logic wr_intr;
   logic wr_sec;
   logic wr_upper;
   logic access_ok;
   // Stored control word: plain fields, the status flag, and the word as read.
   logic [31:0] ctrl_rw_reg;
   logic retry_exp_reg;
   logic [31:0] ctrl_reg;

   assign be_mask = {{8{cfg_req.be[3]}}, {8{cfg_req.be[2]}}, {8{cfg_req.be[1]}},
                     {8{cfg_req.be[0]}}};

   // ------------------------------------------------------------------
   // Access check
   // ------------------------------------------------------------------
   // While the lockout bit is set only the secondary side reaches the registers.
   // A refused primary access neither writes nor reads; it gets a retry pulse so
   // that the port logic can return the retry status that the bridge mode needs.
   // The lockout bit stays writable from the secondary side, the only way out.
   // Primary lockout check
   assign access_ok = !(ctrl_reg[BBC_B_LOCKOUT] && cfg_from_primary);

   assign wr_ctrl = cfg_req.wr && access_ok && (cfg_req.addr == BBC_OFF_BUF_CTRL);
   assign wr_intr = cfg_req.wr && access_ok && (cfg_req.addr == BBC_OFF_INTR);
   assign wr_sec = cfg_req.wr && access_ok && (cfg_req.addr == BBC_OFF_SEC_CMD);
   assign wr_upper = cfg_req.wr && access_ok && (cfg_req.addr == BBC_OFF_UPPER_BASE);

   // ------------------------------------------------------------------
   // Buffering and chip control register
   // ------------------------------------------------------------------
   logic [31:0] ctrl_wmask;

   // The loopback bit is read-only in forward mode, so it drops out of the mask.
   always_comb
   begin
      ctrl_wmask = BBC_CTRL_WMASK & be_mask;
      if (!reverse_mode)
      begin
         ctrl_wmask[BBC_B_LOOPBACK] = 1'b0;
      end
   end

   // Plain read/write fields. The mask keeps reserved bits 3 and 11 and the
   // status bit at their reset values, so one masked merge covers the word.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ctrl_rw_reg <= BBC_RST_BUF_CTRL;
      end
      else if (wr_ctrl)
      begin
         ctrl_rw_reg <= (ctrl_rw_reg & ~ctrl_wmask) | (cfg_req.wdata & ctrl_wmask);
      end
   end

   // Retry expiry flag; a new expiry in the clearing cycle wins over the clear.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         retry_exp_reg <= BBC_RST_BUF_CTRL[BBC_B_RETRY_EXP];
      end
      else if (retry_expired)
      begin
         retry_exp_reg <= 1'b1;
      end
      else if (wr_ctrl && cfg_req.be[2] && cfg_req.wdata[BBC_B_RETRY_EXP])
      begin
         retry_exp_reg <= 1'b0;
      end
   end

   // The flag sits in its own flop so set and clear priority stays in one place.
   // Bit 16 of the plain store never moves: its mask and reset bits are zero.
   assign ctrl_reg = {ctrl_rw_reg[31:17], retry_exp_reg, ctrl_rw_reg[15:0]};

   // ------------------------------------------------------------------
   // Other writable registers
   // ------------------------------------------------------------------
   logic [31:0] upper_reg;
   logic [7:0] intr_line_reg;
   logic [15:0] sec_cmd_reg;
   logic [31:0] upper_wmask;

   assign upper_wmask = upper_setup[31] ? (upper_setup & be_mask) : 32'h0000_0000;

   // Upper window base; cleared while its setup disables it.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         upper_reg <= BBC_RST_UPPER_BASE;
      end
      else if (!upper_setup[31])
      begin
         upper_reg <= BBC_RST_UPPER_BASE;
      end
      else if (wr_upper)
      begin
         upper_reg <= (upper_reg & ~upper_wmask) | (cfg_req.wdata & upper_wmask);
      end
   end

   // Interrupt line byte and secondary command word.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         intr_line_reg <= BBC_RST_INTR_LINE;
         sec_cmd_reg <= BBC_RST_SEC_CMD;
      end
      else
      begin
         if (wr_intr && cfg_req.be[0])
         begin
            intr_line_reg <= cfg_req.wdata[7:0];
         end
         if (wr_sec)
         begin
            sec_cmd_reg <= (sec_cmd_reg & ~(BBC_SEC_CMD_WMASK & be_mask[15:0]))
                           | (cfg_req.wdata[15:0] & BBC_SEC_CMD_WMASK & be_mask[15:0]);
         end
      end
   end

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   logic [31:0] rdata_next;
   logic [31:0] rdata_reg;
   logic ack_reg;
   logic retry_reg;

   // Reserved offsets 28h and 30h read zero like any unmapped offset.
   // Read data is driven only for an accepted read, so the port sees
   // zero on every other cycle and needs no qualifying of its own.
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      unique case (cfg_req.addr)
         BBC_OFF_UPPER_BASE: rdata_next = upper_reg;
         BBC_OFF_SUBSYS: rdata_next = {BBC_SUBSYS_DEVICE, BBC_SUBSYS_VENDOR};
         BBC_OFF_CAP_PTR: rdata_next = BBC_CAP_PTR_VAL;
         BBC_OFF_ROM_BASE: rdata_next = BBC_ROM_BASE_VAL;
         BBC_OFF_INTR: rdata_next = {BBC_MAX_LAT_VAL, BBC_MIN_GRANT_VAL,
                                     reverse_mode ? BBC_INTR_PIN_REV : BBC_INTR_PIN_FWD,
                                     intr_line_reg};
         BBC_OFF_BUF_CTRL: rdata_next = ctrl_reg;
         BBC_OFF_SEC_CMD: rdata_next = {16'h0000, sec_cmd_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // One-cycle answer; a locked-out primary access answers with retry instead.
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
         retry_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= (cfg_req.rd || cfg_req.wr) && access_ok;
         retry_reg <= (cfg_req.rd || cfg_req.wr) && !access_ok;
         rdata_reg <= (cfg_req.rd && access_ok) ? rdata_next : 32'h0000_0000;
      end
   end

   assign cfg_rdata = rdata_reg;
   assign cfg_ack = ack_reg;
   assign cfg_lockout_retry = retry_reg;

   // ------------------------------------------------------------------
   // Decoded settings for the datapath
   // ------------------------------------------------------------------
   // Every field is decoded next to its register so the datapath never
   // needs the encodings. Prefetch modes pass as raw codes because their
   // meaning depends on the bus mode, which this block does not see.
   // Reserved codes decode to the documented fallbacks rather than to a
   // separate error, since software may legally write them.
   always_comb
   begin
      ctrl.park_self = ctrl_reg[BBC_B_PARK];
      ctrl.dyn_prefetch_off = ctrl_reg[BBC_B_DYN_DIS];
      ctrl.predict_off = ctrl_reg[BBC_B_PRED_DIS];
      ctrl.rd_mult_mode = ctrl_reg[BBC_F_RDMULT_LO +: 2];
      ctrl.rd_line_mode = ctrl_reg[BBC_F_RDLINE_LO +: 2];
      ctrl.rd_plain_mode = ctrl_reg[BBC_F_RDPLAIN_LO +: 2];
      ctrl.special_rd = ctrl_reg[BBC_B_SPECIAL_RD];
      unique case (ctrl_reg[BBC_F_MAXRD_LO +: 3])
         3'b001: ctrl.max_rd_bytes = BBC_BYTES_128;
         3'b010: ctrl.max_rd_bytes = BBC_BYTES_256;
         3'b100: ctrl.max_rd_bytes = BBC_BYTES_1024;
         3'b101: ctrl.max_rd_bytes = BBC_BYTES_2048;
         3'b110: ctrl.max_rd_bytes = BBC_BYTES_4096;
         default: ctrl.max_rd_bytes = BBC_BYTES_512;
      endcase
      ctrl.fc_every_credit = ctrl_reg[BBC_B_FC_RATE];
      ctrl.retry_unlimited = (ctrl_reg[BBC_F_RETRY_LO +: 2] == 2'b00);
      unique case (ctrl_reg[BBC_F_RETRY_LO +: 2])
         2'b01: ctrl.retry_limit = BBC_RETRY_LIM_256;
         2'b10: ctrl.retry_limit = BBC_RETRY_LIM_64K;
         2'b11: ctrl.retry_limit = BBC_RETRY_LIM_2G;
         default: ctrl.retry_limit = 32'h0000_0000;
      endcase
      ctrl.discard_off = ctrl_reg[BBC_B_DISC_DIS] || !bridge_discard_en;
      ctrl.discard_short = ctrl_reg[BBC_B_DISC_SHORT];
      // Timer counts assume the 250 MHz clock; another clock needs new
      // package constants, not new logic.
      // Config retry timer
      unique case (ctrl_reg[BBC_F_CRS_LO +: 2])
         2'b00: ctrl.crs_cycles = BBC_CRS_CYC_0;
         2'b01: ctrl.crs_cycles = BBC_CRS_CYC_1;
         2'b10: ctrl.crs_cycles = BBC_CRS_CYC_2;
         2'b11: ctrl.crs_cycles = BBC_CRS_CYC_3;
      endcase
      ctrl.in_order = ctrl_reg[BBC_B_IN_ORDER];
      ctrl.cpl_off = (ctrl_reg[BBC_F_CPL_LO +: 2] == 2'b11);
      ctrl.cpl_cycles = (ctrl_reg[BBC_F_CPL_LO +: 2] == 2'b00) ? BBC_CPL_CYC_0 : BBC_CPL_CYC_1;
      ctrl.traffic_class = ctrl_reg[BBC_B_ISO_EN] ? ctrl_reg[BBC_F_TC_LO +: 3] : 3'b000;
      ctrl.loopback = ctrl_reg[BBC_B_LOOPBACK] && loop_straps_ok;
      ctrl.cfg_lockout = ctrl_reg[BBC_B_LOCKOUT];
   end

   assign discard_bridge_sel = reverse_mode ? bridge_tmo_rev : bridge_tmo_fwd;

   assign upper_base = upper_reg;
   assign sec_cmd = sec_cmd_reg;
   assign intr_line = intr_line_reg;

endmodule : bbc_regs

// File: rtl/bbc_pkg.sv
// Package of offsets, field positions, reset values and carrier types for the buffering registers.
package bbc_pkg;

   // ------------------------------------------------------------------
   // Register offsets (dword aligned byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] BBC_OFF_UPPER_BASE = 8'h24;
   localparam logic [7:0] BBC_OFF_SUBSYS = 8'h2c;
   localparam logic [7:0] BBC_OFF_CAP_PTR = 8'h34;
   localparam logic [7:0] BBC_OFF_ROM_BASE = 8'h38;
   localparam logic [7:0] BBC_OFF_INTR = 8'h3c;
   localparam logic [7:0] BBC_OFF_BUF_CTRL = 8'h40;
   localparam logic [7:0] BBC_OFF_SEC_CMD = 8'h44;

   // ------------------------------------------------------------------
   // Field positions in the buffering and chip control word
   // ------------------------------------------------------------------
   localparam int BBC_B_PARK = 0;
   localparam int BBC_B_DYN_DIS = 1;
   localparam int BBC_B_PRED_DIS = 2;
   localparam int BBC_F_RDMULT_LO = 4;
   localparam int BBC_F_RDLINE_LO = 6;
   localparam int BBC_F_RDPLAIN_LO = 8;
   localparam int BBC_B_SPECIAL_RD = 10;
   localparam int BBC_F_MAXRD_LO = 12;
   localparam int BBC_B_FC_RATE = 15;
   localparam int BBC_B_RETRY_EXP = 16;
   localparam int BBC_F_RETRY_LO = 17;
   localparam int BBC_B_DISC_DIS = 19;
   localparam int BBC_B_DISC_SHORT = 20;
   localparam int BBC_F_CRS_LO = 21;
   localparam int BBC_B_IN_ORDER = 23;
   localparam int BBC_F_CPL_LO = 24;
   localparam int BBC_B_ISO_EN = 26;
   localparam int BBC_F_TC_LO = 27;
   localparam int BBC_B_LOOPBACK = 30;
   localparam int BBC_B_LOCKOUT = 31;

   // ------------------------------------------------------------------
   // Values after reset, write masks and fixed read values
   // ------------------------------------------------------------------
   localparam logic [31:0] BBC_RST_BUF_CTRL = 32'h0920_0020;
   localparam logic [31:0] BBC_CTRL_WMASK = 32'hFFFE_F7F7;
   localparam logic [31:0] BBC_CAP_PTR_VAL = 32'h0000_0080;
   localparam logic [31:0] BBC_ROM_BASE_VAL = 32'h0000_0000;
   localparam logic [31:0] BBC_RST_UPPER_BASE = 32'h0000_0000;
   localparam logic [7:0] BBC_RST_INTR_LINE = 8'h00;
   localparam logic [7:0] BBC_INTR_PIN_REV = 8'h01;
   localparam logic [7:0] BBC_INTR_PIN_FWD = 8'h00;
   localparam logic [7:0] BBC_MIN_GRANT_VAL = 8'h00;
   localparam logic [7:0] BBC_MAX_LAT_VAL = 8'h00;
   localparam logic [15:0] BBC_SEC_CMD_WMASK = 16'h0547;
   localparam logic [15:0] BBC_RST_SEC_CMD = 16'h0000;
   localparam logic [15:0] BBC_SUBSYS_VENDOR = 16'h0000;
   localparam logic [15:0] BBC_SUBSYS_DEVICE = 16'h0000;

   // ------------------------------------------------------------------
   // Decoded timer counts and byte counts
   // ------------------------------------------------------------------
   localparam logic [7:0] BBC_DISC_SHORT_CLKS = 8'h40;
   localparam logic [31:0] BBC_RETRY_LIM_256 = 32'h0000_0100;
   localparam logic [31:0] BBC_RETRY_LIM_64K = 32'h0001_0000;
   localparam logic [31:0] BBC_RETRY_LIM_2G = 32'h8000_0000;
   localparam logic [12:0] BBC_BYTES_128 = 13'h0080;
   localparam logic [12:0] BBC_BYTES_256 = 13'h0100;
   localparam logic [12:0] BBC_BYTES_512 = 13'h0200;
   localparam logic [12:0] BBC_BYTES_1024 = 13'h0400;
   localparam logic [12:0] BBC_BYTES_2048 = 13'h0800;
   localparam logic [12:0] BBC_BYTES_4096 = 13'h1000;

   // Timer periods in microseconds, and the cycle counts at 250 MHz.
   localparam int BBC_CLK_MHZ = 250;
   localparam int BBC_CRS_US_0 = 25;
   localparam int BBC_CRS_US_1 = 500;
   localparam int BBC_CRS_US_2 = 5000;
   localparam int BBC_CRS_US_3 = 25000;
   localparam int BBC_CPL_US_0 = 50;
   localparam int BBC_CPL_US_1 = 10000;
   localparam logic [23:0] BBC_CRS_CYC_0 = 24'(BBC_CRS_US_0 * BBC_CLK_MHZ);
   localparam logic [23:0] BBC_CRS_CYC_1 = 24'(BBC_CRS_US_1 * BBC_CLK_MHZ);
   localparam logic [23:0] BBC_CRS_CYC_2 = 24'(BBC_CRS_US_2 * BBC_CLK_MHZ);
   localparam logic [23:0] BBC_CRS_CYC_3 = 24'(BBC_CRS_US_3 * BBC_CLK_MHZ);
   localparam logic [23:0] BBC_CPL_CYC_0 = 24'(BBC_CPL_US_0 * BBC_CLK_MHZ);
   localparam logic [23:0] BBC_CPL_CYC_1 = 24'(BBC_CPL_US_1 * BBC_CLK_MHZ);

   // Configuration access carried from the configuration port.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } bbc_cfg_req_t;

   // Decoded settings handed to the datapath.
   typedef struct packed {
      logic park_self;
      logic dyn_prefetch_off;
      logic predict_off;
      logic [1:0] rd_mult_mode;
      logic [1:0] rd_line_mode;
      logic [1:0] rd_plain_mode;
      logic special_rd;
      logic [12:0] max_rd_bytes;
      logic fc_every_credit;
      logic [31:0] retry_limit;
      logic retry_unlimited;
      logic discard_off;
      logic discard_short;
      logic [23:0] crs_cycles;
      logic in_order;
      logic cpl_off;
      logic [23:0] cpl_cycles;
      logic [2:0] traffic_class;
      logic loopback;
      logic cfg_lockout;
   } bbc_ctrl_t;

endpackage : bbc_pkg

// File: sim/bbc_regs_props.sv
// Concurrent checks on the configuration port and the decoded control word.
module bbc_regs_props
   import bbc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire bbc_cfg_req_t cfg_req,
   input wire logic cfg_from_primary,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   input wire logic cfg_lockout_retry,
   input wire logic [31:0] upper_setup,
   input wire logic retry_expired,
   input wire logic bridge_discard_en,
   input wire bbc_ctrl_t ctrl,
   input wire logic [31:0] upper_base
);
   logic req;
   logic lock;

   // A primary access while the lockout bit is set must be refused, not served.
   assign req = cfg_req.wr || cfg_req.rd;
   assign lock = ctrl.cfg_lockout && cfg_from_primary;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_req_ok;
      req && !lock;
   endsequence
   sequence s_wr40;
      cfg_req.wr && cfg_req.addr == BBC_OFF_BUF_CTRL && !lock;
   endsequence
   sequence s_rd40;
      cfg_req.rd && cfg_req.addr == BBC_OFF_BUF_CTRL && !lock;
   endsequence

   property p_ack;
      s_req_ok |=> cfg_ack && !cfg_lockout_retry;
   endproperty
   property p_lock;
      req && lock |=> cfg_lockout_retry && !cfg_ack;
   endproperty
   property p_idle;
      !req |=> !cfg_ack && !cfg_lockout_retry;
   endproperty
   property p_rd_zero;
      !cfg_ack |-> cfg_rdata == 32'h0000_0000;
   endproperty
   property p_cap;
      cfg_req.rd && cfg_req.addr == BBC_OFF_CAP_PTR && !lock |=> cfg_rdata == 32'h0000_0080;
   endproperty
   property p_sticky;
      retry_expired ##1 !cfg_req.wr ##1 s_rd40 |=> cfg_rdata[16];
   endproperty
   property p_maxrd;
      s_wr40 ##0 (cfg_req.be[1] && cfg_req.wdata[14:12] == 3'h6) |=>
         ctrl.max_rd_bytes == 13'h1000;
   endproperty
   property p_cpl;
      s_wr40 ##0 (cfg_req.be[3] && cfg_req.wdata[25:24] == 2'h3) |=> ctrl.cpl_off;
   endproperty
   property p_disc;
      !bridge_discard_en |-> ctrl.discard_off;
   endproperty
   property p_upper;
      !upper_setup[31] |=> upper_base == 32'h0000_0000;
   endproperty

   a_ack: assert property (p_ack) else $error("access not acknowledged");
   a_lock: assert property (p_lock) else $error("locked access not refused");
   a_idle: assert property (p_idle) else $error("answer without request");
   a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
   a_cap: assert property (p_cap) else $error("capability pointer wrong");
   a_sticky: assert property (p_sticky) else $error("retry status not set");
   a_maxrd: assert property (p_maxrd) else $error("read byte count wrong");
   a_cpl: assert property (p_cpl) else $error("completion timer not off");
   a_disc: assert property (p_disc) else $error("discard timer not off");
   a_upper: assert property (p_upper) else $error("upper base not cleared");
endmodule : bbc_regs_props

bind bbc_regs bbc_regs_props u_props (.clk, .resetn, .cfg_req, .cfg_from_primary, .cfg_rdata,
   .cfg_ack, .cfg_lockout_retry, .upper_setup, .retry_expired, .bridge_discard_en, .ctrl,
   .upper_base);

// File: sim/bbc_host.sv
// Host software model that issues single configuration accesses.
module bbc_host
   import bbc_pkg::*;
(
   input wire logic clk,
   output bbc_cfg_req_t cfg_req,
   output logic cfg_from_primary,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_ack,
   input wire logic cfg_lockout_retry
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] rq;
   logic rack;
   logic rrty;

   // Idle until the first access.
   initial
   begin
      cfg_req = '0;
      cfg_from_primary = 1'b1;
   end

   // One-cycle request; the answer is taken at the next edge, before it updates.
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be, input logic prim);
      @(posedge clk);
      cfg_req <= '{wr: w, rd: !w, addr: a, be: be, wdata: d};
      cfg_from_primary <= prim;
      @(posedge clk);
      cfg_req <= '0;
      @(posedge clk);
      rq = cfg_rdata;
      rack = cfg_ack;
      rrty = cfg_lockout_retry;
   endtask : acc
endmodule : bbc_host

// File: sim/bbc_regs_tb.sv
// Self-checking bench for the buffering and chip control register block.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module bbc_regs_tb import bbc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic resetn;
   logic [31:0] upper_setup;
   logic retry_expired;
   logic bridge_discard_en;
   logic [4:0] straps;
   bbc_cfg_req_t cfg_req;
   logic cfg_from_primary;
   logic [31:0] cfg_rdata;
   logic cfg_ack;
   logic cfg_lockout_retry;
   bbc_ctrl_t ctrl;
   logic [31:0] upper_base;
   logic [15:0] sec_cmd;
   logic [7:0] intr_line;
   logic discard_bridge_sel;
   int n_mismatch;
   int n_tests;
   int cyc;
   logic [7:0] rd_adr [6];
   logic [31:0] rd_exp [6];
   logic [12:0] bytes_exp [8];
   logic [31:0] lim_exp [4];
   logic [23:0] crs_exp [4];

   bbc_regs uut (.clk, .resetn, .cfg_req, .cfg_from_primary, .cfg_rdata, .cfg_ack,
      .cfg_lockout_retry, .upper_setup, .retry_expired, .bridge_discard_en,
      .bridge_tmo_fwd(1'b1), .bridge_tmo_rev(1'b0), .test_mode_strap_a(straps[4]),
      .test_mode_strap_b(straps[3]), .test_mode_strap_c(straps[2]),
      .mask_input_strap(straps[1]), .reverse_mode_strap(straps[0]), .ctrl, .upper_base,
      .sec_cmd, .intr_line, .discard_bridge_sel);
   bbc_host u_host (.clk, .cfg_req, .cfg_from_primary, .cfg_rdata, .cfg_ack,
      .cfg_lockout_retry);

   task automatic rd(input logic [7:0] a);
      u_host.acc(1'b0, a, 32'h0000_0000, 4'hF, 1'b0);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
      input logic prim);
      u_host.acc(1'b1, a, d, be, prim);
   endtask : wr
   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // Free-running clock.
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // The whole run needs about 110 cycles, so a hang is cut at 2000.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      resetn = 1'b0;
      upper_setup = 32'h0000_0000;
      retry_expired = 1'b0;
      bridge_discard_en = 1'b1;
      straps = 5'h00;
      rd_adr = '{BBC_OFF_CAP_PTR, BBC_OFF_ROM_BASE, BBC_OFF_INTR, BBC_OFF_SUBSYS, 8'h30,
         BBC_OFF_BUF_CTRL};
      rd_exp = '{32'h0000_0080, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
         32'h0920_0020};
      bytes_exp = '{13'h0200, 13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800, 13'h1000,
         13'h0200};
      lim_exp = '{32'h0000_0000, 32'h0000_0100, 32'h0001_0000, 32'h8000_0000};
      crs_exp = '{BBC_CRS_CYC_0, BBC_CRS_CYC_1, BBC_CRS_CYC_2, BBC_CRS_CYC_3};
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         rd(rd_adr[i]);
         `CHK("reset word", rd_exp[i], u_host.rq)
         `CHK("ack", 1'b1, u_host.rack)
      end
      // All ones from the secondary side; forward mode keeps bit 30 read-only.
      wr(BBC_OFF_BUF_CTRL, 32'hFFFF_FFFF, 4'hF, 1'b0);
      `CHK("park", 1'b1, ctrl.park_self)
      `CHK("special", 1'b1, ctrl.special_rd)
      `CHK("fc rate", 1'b1, ctrl.fc_every_credit)
      `CHK("in order", 1'b1, ctrl.in_order)
      `CHK("tc", 3'h7, ctrl.traffic_class)
      wr(BBC_OFF_BUF_CTRL, 32'h0000_0000, 4'hF, 1'b1);
      `CHK("lock retry", 1'b1, u_host.rrty)
      `CHK("lock ack", 1'b0, u_host.rack)
      rd(BBC_OFF_BUF_CTRL);
      `CHK("all ones", 32'hBFFE_F7F7, u_host.rq)
      // Every code of the byte count, retry, config retry and completion fields.
      for (int i = 0; i < 8; i++)
      begin
         wr(BBC_OFF_BUF_CTRL, {2'h0, 3'(i), 1'b1, i[1:0], 1'b0, i[1:0], i[0], 1'b0, i[1:0],
            2'h0, 3'(i), 12'h000}, 4'hF, 1'b0);
         `CHK("max rd", bytes_exp[i], ctrl.max_rd_bytes)
         `CHK("unlimited", i % 4 == 0, ctrl.retry_unlimited)
         `CHK("limit", lim_exp[i % 4], ctrl.retry_unlimited ? 32'h0 : ctrl.retry_limit)
         `CHK("crs", crs_exp[i % 4], ctrl.crs_cycles)
         `CHK("cpl off", i % 4 == 3, ctrl.cpl_off)
         `CHK("cpl", (i % 4 == 0) ? BBC_CPL_CYC_0 : BBC_CPL_CYC_1,
            (i % 4 == 3) ? BBC_CPL_CYC_1 : ctrl.cpl_cycles)
         `CHK("short", i[0], ctrl.discard_short)
      end
      `CHK("disc on", 1'b0, ctrl.discard_off)
      `CHK("bridge sel", 1'b1, discard_bridge_sel)
      @(posedge clk);
      bridge_discard_en <= 1'b0;
      @(posedge clk);
      #1;
      `CHK("disc off", 1'b1, ctrl.discard_off)
      @(posedge clk);
      bridge_discard_en <= 1'b1;
      retry_expired <= 1'b1;
      @(posedge clk);
      retry_expired <= 1'b0;
      rd(BBC_OFF_BUF_CTRL);
      wr(BBC_OFF_BUF_CTRL, 32'h0000_0000, 4'hF, 1'b0);
      rd(BBC_OFF_BUF_CTRL);
      `CHK("sticky", 1'b1, u_host.rq[16])
      wr(BBC_OFF_BUF_CTRL, 32'h0001_0000, 4'hF, 1'b0);
      rd(BBC_OFF_BUF_CTRL);
      `CHK("cleared", 1'b0, u_host.rq[16])
      @(posedge clk);
      upper_setup <= 32'h8000_00FF;
      wr(BBC_OFF_UPPER_BASE, 32'hFFFF_FFFF, 4'hF, 1'b0);
      rd(BBC_OFF_UPPER_BASE);
      `CHK("upper", 32'h8000_00FF, u_host.rq)
      @(posedge clk);
      upper_setup <= 32'h0000_00FF;
      rd(BBC_OFF_UPPER_BASE);
      `CHK("upper off", 32'h0000_0000, upper_base)
      wr(BBC_OFF_INTR, 32'hFFFF_FFA5, 4'h1, 1'b0);
      wr(8'h30, 32'hFFFF_FFFF, 4'hF, 1'b0);
      rd(8'h30);
      `CHK("unmapped", 32'h0000_0000, u_host.rq)
      rd(BBC_OFF_INTR);
      `CHK("intr", 32'h0000_00A5, u_host.rq)
      `CHK("intr line", 8'hA5, intr_line)
      wr(BBC_OFF_SEC_CMD, 32'hFFFF_FFFF, 4'h3, 1'b0);
      `CHK("sec cmd", BBC_SEC_CMD_WMASK, sec_cmd)
      // Reverse mode with the loopback strap pattern; straps need a few edges to sync.
      @(posedge clk);
      straps <= 5'h0F;
      repeat (6) @(posedge clk);
      wr(BBC_OFF_BUF_CTRL, 32'h4000_0000, 4'hF, 1'b0);
      `CHK("loopback", 1'b1, ctrl.loopback)
      `CHK("rev sel", 1'b0, discard_bridge_sel)
      rd(BBC_OFF_INTR);
      `CHK("pin", 8'h01, u_host.rq[15:8])
      tally_and_finish();
   end
endmodule : bbc_regs_tb
